// ==== shared/dtc_pkg.sv ====
// Package for the dual timer control block: register map, field positions, timing.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package dtc_pkg;
   localparam logic [7:0] DTC_CTRL_OFS = 8'h0C;
   localparam logic [7:0] DTC_CFG_OFS = 8'h00;
   localparam logic [7:0] DTC_STAT_OFS = 8'h40;
   localparam int DTC_A_RUN_BIT = 0;
   localparam int DTC_A_FREEZE_BIT = 1;
   localparam int DTC_A_EDGE_LSB = 2;
   localparam int DTC_RTC_RUN_BIT = 4;
   localparam int DTC_A_INV_BIT = 6;
   localparam int DTC_B_RUN_BIT = 8;
   localparam int DTC_B_FREEZE_BIT = 9;
   localparam logic [31:0] DTC_CTRL_WMASK = 32'h0000_035F;
   localparam logic [31:0] DTC_CTRL_RESET = 32'h0000_0000;
   localparam logic [2:0] DTC_CFG_RESET = 3'h0;
   localparam logic [1:0] DTC_EDGE_RISE = 2'h0;
   localparam logic [1:0] DTC_EDGE_FALL = 2'h1;
   localparam logic [1:0] DTC_EDGE_BOTH = 2'h3;
   localparam int DTC_CLK_MHZ = 100;
   localparam int DTC_RTC_TICK_US = 1;
   localparam int DTC_RTC_TICK_CYC = DTC_RTC_TICK_US * DTC_CLK_MHZ;
   localparam int DTC_WIDTH = 16;
   typedef enum logic [1:0] {
      DTC_IDLE = 2'b00,
      DTC_RUN = 2'b01,
      DTC_HOLD = 2'b11
   } dtc_state_t;
endpackage

// ==== sim/dtc_top_bench.sv ====
// Self-checking bench for the dual timer control block.
// Assumes the shared package and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dtc_top_bench;
   import dtc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} dtc_row_t;
   logic mclk_in, rst_b_in, ce_in, wr_in, rd_in, debug_halt_in, first_half_pwm_in;
   logic first_event_in, second_event_in, first_half_pwm_out;
   logic [7:0] addr_in;
   logic [31:0] wdata_in, rdata_out, rtc_count_out, rv, r0, s0, s1, s2;
   logic [15:0] first_count_out, second_count_out, c0;
   int err_count = 0;
   int checked = 0;
   dtc_row_t rows [6];
   dtc_top #(.WIDTH(16)) dtc_top_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .debug_halt_in(debug_halt_in),
      .first_half_pwm_in(first_half_pwm_in), .first_event_in(first_event_in),
      .second_event_in(second_event_in), .first_half_pwm_out(first_half_pwm_out),
      .first_count_out(first_count_out), .second_count_out(second_count_out),
      .rtc_count_out(rtc_count_out));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask
   task automatic delta(input int h, input int k, input logic [15:0] e);
      @(posedge mclk_in);
      #1;
      c0 = h ? second_count_out : first_count_out;
      repeat (k) @(posedge mclk_in);
      #1;
      chk("count step", {16'h0000, e}, {16'h0000, (h ? second_count_out : first_count_out) - c0});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6000) @(posedge mclk_in);
      err_count++;
      finish_test();
   end
   initial begin
      rows[0] = '{8'h0C, 32'hFFFF_FFFF, 32'h0000_035F};
      rows[1] = '{8'h0C, 32'h0000_00A0, 32'h0000_0000};
      rows[2] = '{8'h0C, 32'h0000_0004, 32'h0000_0004};
      rows[3] = '{8'h0C, 32'h0000_000C, 32'h0000_000C};
      rows[4] = '{8'h0C, 32'h0000_0000, 32'h0000_0000};
      rows[5] = '{8'h84, 32'hFFFF_FFFF, 32'h0000_0000};
      {rst_b_in, wr_in, rd_in, debug_halt_in, first_half_pwm_in} = 5'h00;
      {first_event_in, second_event_in} = 2'h0;
      ce_in = 1'b1;
      addr_in = 8'h00;
      wdata_in = 32'h0000_0000;
      repeat (6) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      rd(DTC_CTRL_OFS, rv);
      chk("control reset", DTC_CTRL_RESET, rv);
      chk("count reset", 32'h0000_0000, {first_count_out, second_count_out});
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rv);
         chk("readback", rows[i].r, rv);
      end
      for (int h = 0; h < 2; h++) begin
         for (int m = 0; m < 4; m++) begin
            debug_halt_in <= (m == 1 || m == 2);
            wr(DTC_CTRL_OFS, (m > 0) << (h ? DTC_B_RUN_BIT : DTC_A_RUN_BIT) |
               (m > 1) << (h ? DTC_B_FREEZE_BIT : DTC_A_FREEZE_BIT));
            repeat (3) @(posedge mclk_in);
            delta(h, 8, (m == 0 || m == 2) ? 16'h0000 : 16'h0008);
         end
      end
      debug_halt_in <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(DTC_CTRL_OFS, i << DTC_A_INV_BIT);
         for (int p = 0; p < 2; p++) begin
            first_half_pwm_in <= p[0];
            repeat (2) @(posedge mclk_in);
            #1;
            chk("pwm level", {31'h0000_0000, p[0] ^ i[0]}, {31'h0000_0000, first_half_pwm_out});
         end
      end
      for (int i = 0; i < 2; i++) begin
         wr(DTC_CTRL_OFS, i << DTC_RTC_RUN_BIT);
         repeat (5) @(posedge mclk_in);
         #1;
         r0 = rtc_count_out;
         repeat (3 * DTC_RTC_TICK_CYC) @(posedge mclk_in);
         #1;
         chk("rtc step", 32'(3 * i), rtc_count_out - r0);
      end
      wr(DTC_CFG_OFS, 32'h0000_0001);
      for (int e = 0; e < 4; e++) begin
         wr(DTC_CTRL_OFS, 32'h0000_0001 | e << DTC_A_EDGE_LSB);
         repeat (4) @(posedge mclk_in);
         rd(DTC_STAT_OFS, s0);
         first_event_in <= 1'b1;
         repeat (4) @(posedge mclk_in);
         rd(DTC_STAT_OFS, s1);
         first_event_in <= 1'b0;
         repeat (4) @(posedge mclk_in);
         rd(DTC_STAT_OFS, s2);
         chk("rise capture", {31'h0000_0000, e == 0 || e == 3}, {31'h0000_0000, s1[15:0] !== s0[15:0]});
         chk("fall capture", {31'h0000_0000, e == 1 || e == 3}, {31'h0000_0000, s2[15:0] !== s1[15:0]});
      end
      wr(DTC_CTRL_OFS, 32'h0000_0100);
      repeat (4) @(posedge mclk_in);
      rd(DTC_STAT_OFS, s0);
      second_event_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      rd(DTC_STAT_OFS, s1);
      chk("second capture", 32'h0000_0001, {31'h0000_0000, s1[31:16] !== s0[31:16]});
      wr(DTC_CTRL_OFS, 32'h0000_035F);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      rd(DTC_CTRL_OFS, rv);
      chk("control rereset", DTC_CTRL_RESET, rv);
      finish_test();
   end
endmodule // dtc_top_bench
`default_nettype wire

// ==== verilog/dtc_half.sv ====
// One 16-bit timer half: counts up or captures on the selected edge.
// Assumes synchronous inputs and the shared clock enable.
`timescale 1ns/1ps
`default_nettype none
module dtc_half #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Control
   input wire logic run_in,
   input wire logic freeze_in,
   input wire logic capture_in,
   input wire logic [1:0] edge_sel_in,
   input wire logic event_in,
   // Status
   output logic [WIDTH-1:0] count_out,
   output logic [WIDTH-1:0] capt_out,
   output var dtc_pkg::dtc_state_t state_out
);
   import dtc_pkg::*;
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] capt_q;
   logic event_q;
   dtc_state_t state_q;
   dtc_state_t state_d;
   wire rise = event_in & ~event_q;
   wire fall = ~event_in & event_q;
   wire edge_hit = (edge_sel_in == DTC_EDGE_RISE) ? rise :
                   (edge_sel_in == DTC_EDGE_FALL) ? fall :
                   (edge_sel_in == DTC_EDGE_BOTH) ? (rise | fall) : 1'b0;
   always_comb begin
      case (state_q)
         DTC_IDLE: state_d = run_in ? (freeze_in ? DTC_HOLD : DTC_RUN) : DTC_IDLE;
         DTC_RUN: state_d = !run_in ? DTC_IDLE : (freeze_in ? DTC_HOLD : DTC_RUN);
         DTC_HOLD: state_d = !run_in ? DTC_IDLE : (freeze_in ? DTC_HOLD : DTC_RUN);
         default: state_d = DTC_IDLE;
      endcase
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state_q <= DTC_IDLE;
         count_q <= '0;
         capt_q <= '0;
         event_q <= 1'b0;
      end else if (ce_in) begin
         state_q <= state_d;
         event_q <= event_in;
         if (state_d == DTC_RUN)
            count_q <= count_q + 1'b1;
         if (state_d == DTC_RUN && capture_in && edge_hit)
            capt_q <= count_q;
      end
   end
   assign count_out = count_q;
   assign capt_out = capt_q;
   assign state_out = state_q;
endmodule // dtc_half
`default_nettype wire

// ==== verilog/dtc_top.sv ====
// Functional notes
// - Bit 9 set freezes the second half during a debug halt.
// - Bit 1 set freezes the first half during a debug halt.
// - Bit 8 runs the second half, counting or capture per configuration.
// - Bit 0 runs the first half, counting or capture per configuration.
// - Bit 6 inverts the first half PWM output.
// - Bit 4 lets the real-time clock advance; zero holds it.
// - Bits 3:2 pick the first half capture edge: rise, fall, or both; code 2 reserved.
// - Bits 7 and 5 are read-only zero.
//
// Control bits of a dual 16-bit timer, with register port and two halves.
// Assumes one clock, synchronous inputs, strobe-style register master.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtc_top #(
   parameter int WIDTH = dtc_pkg::DTC_WIDTH
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Processor and events
   input wire logic debug_halt_in,
   input wire logic first_half_pwm_in,
   input wire logic first_event_in,
   input wire logic second_event_in,
   // Outputs
   output logic first_half_pwm_out,
   output logic [WIDTH-1:0] first_count_out,
   output logic [WIDTH-1:0] second_count_out,
   output logic [31:0] rtc_count_out
);
   import dtc_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_q;
   logic [2:0] cfg_q;
   logic [31:0] rdata_q;
   logic [31:0] rtc_q;
   logic [31:0] tick_q;
   logic pwm_q;
   wire first_half_run = ctrl_q[DTC_A_RUN_BIT];
   wire first_half_debug_freeze = ctrl_q[DTC_A_FREEZE_BIT];
   wire [1:0] first_half_capture_edge = ctrl_q[DTC_A_EDGE_LSB +: 2];
   wire rtc_count_run = ctrl_q[DTC_RTC_RUN_BIT];
   wire first_half_pwm_invert = ctrl_q[DTC_A_INV_BIT];
   wire second_half_run = ctrl_q[DTC_B_RUN_BIT];
   wire second_half_debug_freeze = ctrl_q[DTC_B_FREEZE_BIT];
   wire is_capture = (cfg_q != DTC_CFG_RESET);
   wire wr_ctrl = wr_in && (addr_in == DTC_CTRL_OFS);
   wire wr_cfg = wr_in && (addr_in == DTC_CFG_OFS);
   wire [WIDTH-1:0] first_capt;
   wire [WIDTH-1:0] second_capt;
   dtc_state_t first_state;
   dtc_state_t second_state;
   wire first_freeze = debug_halt_in & first_half_debug_freeze;
   wire second_freeze = debug_halt_in & second_half_debug_freeze;
   wire [31:0] rd_mux = (addr_in == DTC_CTRL_OFS) ? ctrl_q :
                        (addr_in == DTC_CFG_OFS) ? {29'h0000_0000, cfg_q} :
                        (addr_in == DTC_STAT_OFS) ? 32'({second_capt, first_capt}) :
                        32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         ctrl_q <= DTC_CTRL_RESET;
         cfg_q <= DTC_CFG_RESET;
         rdata_q <= 32'h0000_0000;
      end else if (ce_in) begin
         if (wr_ctrl)
            ctrl_q <= wdata_in & DTC_CTRL_WMASK;
         if (wr_cfg)
            cfg_q <= wdata_in[2:0];
         rdata_q <= rd_in ? rd_mux : 32'h0000_0000;
      end
   end
   assign rdata_out = rdata_q;
   ////////////////////////////////////////////////////////////////////////
   // first half
   dtc_half #(.WIDTH(WIDTH)) u_first (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .run_in(first_half_run),
      .freeze_in(first_freeze),
      .capture_in(is_capture),
      .edge_sel_in(first_half_capture_edge),
      .event_in(first_event_in),
      .count_out(first_count_out),
      .capt_out(first_capt),
      .state_out(first_state)
   );
   dtc_half #(.WIDTH(WIDTH)) u_second (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .run_in(second_half_run),
      .freeze_in(second_freeze),
      .capture_in(is_capture),
      .edge_sel_in(DTC_EDGE_RISE),
      .event_in(second_event_in),
      .count_out(second_count_out),
      .capt_out(second_capt),
      .state_out(second_state)
   );
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         rtc_q <= 32'h0000_0000;
         tick_q <= 32'h0000_0000;
         pwm_q <= 1'b0;
      end else if (ce_in) begin
         pwm_q <= first_half_pwm_in ^ first_half_pwm_invert;
         if (rtc_count_run) begin
            if (tick_q == 32'(DTC_RTC_TICK_CYC - 1)) begin
               tick_q <= 32'h0000_0000;
               rtc_q <= rtc_q + 32'h0000_0001;
            end else begin
               tick_q <= tick_q + 32'h0000_0001;
            end
         end
      end
   end
   assign first_half_pwm_out = pwm_q;
   assign rtc_count_out = rtc_q;
   ////////////////////////////////////////////////////////////////////////
   // frozen second half
   a_second_freeze_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && $past(ce_in) && second_freeze && $past(second_freeze) && second_half_run
      && $past(second_half_run) |-> second_count_out == $past(second_count_out))
      else $error("second half moved while frozen");
   a_first_freeze_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && $past(ce_in) && first_freeze && $past(first_freeze)
      |-> first_count_out == $past(first_count_out))
      else $error("first half moved while frozen");
   a_second_off_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !second_half_run && !$past(second_half_run) |-> $stable(second_count_out))
      else $error("second half moved while off");
   a_first_run_count: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && first_half_run && !first_freeze && !is_capture && first_state == DTC_RUN
      |=> first_count_out == $past(first_count_out) + 1'b1)
      else $error("first half did not count");
   a_pwm_invert: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ce_in && !wr_ctrl |=> first_half_pwm_out == ($past(first_half_pwm_in) ^ first_half_pwm_invert))
      else $error("pwm level wrong");
   a_rtc_stopped: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !rtc_count_run |=> rtc_count_out == $past(rtc_count_out))
      else $error("rtc advanced while stopped");
   a_edge_reserved: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      first_half_capture_edge == 2'h2 && !wr_ctrl |=> $stable(first_capt))
      else $error("capture on reserved edge code");
   a_reserved_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rd_in && addr_in == DTC_CTRL_OFS |=> rdata_out[7] == 1'b0 && rdata_out[5] == 1'b0)
      else $error("reserved bits nonzero");
   a_first_off_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !first_half_run && !$past(first_half_run) |-> $stable(first_count_out))
      else $error("first half moved while off");
   sequence s_second_counting;
      ce_in && second_half_run && !second_freeze && !is_capture;
   endsequence
   a_second_run_count: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_second_counting |=> second_count_out == $past(second_count_out) + 1'b1)
      else $error("second half did not count");
   sequence s_rtc_wrap;
      ce_in && rtc_count_run && tick_q == 32'(DTC_RTC_TICK_CYC - 1);
   endsequence
   a_rtc_advance: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      s_rtc_wrap |=> rtc_count_out == $past(rtc_count_out) + 32'h0000_0001)
      else $error("rtc did not advance");
   a_reset_zero: assert property (@(posedge mclk_in)
      !rst_b_in |=> ctrl_q == DTC_CTRL_RESET && rtc_count_out == 32'h0000_0000)
      else $error("control not zero after reset");
endmodule // dtc_top
`default_nettype wire
